// [hw/tsap_pkg.sv]
// package: register map, field layout, modes and timing constants of the serial audio ports
package tsap_pkg;
    // register map, byte addresses; format words for input ports 0-3 then output ports 0-3
    localparam logic [15:0] FMT_BASE_ADDR = 16'hf200;
    localparam logic [15:0] STATUS_ADDR = 16'hf220;
    localparam logic [15:0] FMT_RESET = 16'h0000;
    localparam logic [7:0] FAULT_RESET = 8'h00;
    // format word field positions
    localparam int SLOT_LSB = 0;
    localparam int MSB_POS_LSB = 3;
    localparam int WL_LSB = 5;
    localparam int BIT_POL_BIT = 7;
    localparam int FRAME_POL_BIT = 8;
    localparam int FRAME_MODE_BIT = 9;
    localparam int BIT_SRC_LSB = 10;
    localparam int FRAME_SRC_LSB = 13;
    // slot modes
    localparam logic [2:0] SLOT_2X32 = 3'h0;
    localparam logic [2:0] SLOT_4X32 = 3'h1;
    localparam logic [2:0] SLOT_8X32 = 3'h2;
    localparam logic [2:0] SLOT_16X32 = 3'h3;
    localparam logic [2:0] SLOT_4X16 = 3'h4;
    localparam logic [2:0] SLOT_2X16 = 3'h5;
    // clock source code for master; 0-3 pick a same-direction domain
    localparam logic [2:0] SRC_MASTER = 3'h4;
    // word length codes
    localparam logic [1:0] WL_24 = 2'h0;
    localparam logic [1:0] WL_16 = 2'h1;
    localparam logic [1:0] WL_32 = 2'h2;
    localparam logic [1:0] WL_FLEX = 2'h3;
    // msb delay from frame start, in bit clocks, per msb position code
    localparam logic [8:0] DLY_POS0 = 9'h001;
    localparam logic [8:0] DLY_POS1 = 9'h000;
    localparam logic [8:0] DLY_POS2 = 9'h008;
    localparam logic [8:0] DLY_POS3 = 9'h010;
    // frame rate limits and the cycle counts they give
    localparam int CLK_HZ = 250_000_000;
    localparam int FS_MIN_HZ = 6_000;
    localparam int FS_MAX_HZ = 192_000;
    localparam int FRAME_MAX_CYCLES = CLK_HZ / FS_MIN_HZ;
    localparam int FRAME_MIN_CYCLES = (CLK_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ;
    // master bit clock half period in core cycles
    localparam int MASTER_HALF_DIV = 40;
    // register bus states
    typedef enum logic [1:0] {
        AHB_IDLE = 2'b00,
        AHB_WRITE = 2'b01,
        AHB_READ = 2'b10
    } tsap_ahb_state_t;
endpackage

// [hw/tsap_top.sv]
// four input and four output tdm serial audio ports with an ahb-lite register slave
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module tsap_top #(
    parameter int FRAME_MAX_CYC = tsap_pkg::FRAME_MAX_CYCLES,
    parameter int HALF_DIV = tsap_pkg::MASTER_HALF_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // ahb-lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial data pins
    input wire logic serial_in_line_0,
    input wire logic serial_in_line_1,
    input wire logic serial_in_line_2,
    input wire logic serial_in_line_3,
    output logic serial_out_line_0,
    output logic serial_out_line_1,
    output logic serial_out_line_2,
    output logic serial_out_line_3,
    // input-side clock pins, two-way
    input wire logic [3:0] input_bit_clock_pin_i,
    output logic [3:0] input_bit_clock_pin_o,
    output logic [3:0] input_bit_clock_pin_oe,
    input wire logic [3:0] input_frame_clock_pin_i,
    output logic [3:0] input_frame_clock_pin_o,
    output logic [3:0] input_frame_clock_pin_oe,
    // output-side clock pins, two-way
    input wire logic [3:0] output_bit_clock_pin_i,
    output logic [3:0] output_bit_clock_pin_o,
    output logic [3:0] output_bit_clock_pin_oe,
    input wire logic [3:0] output_frame_clock_pin_i,
    output logic [3:0] output_frame_clock_pin_o,
    output logic [3:0] output_frame_clock_pin_oe,
    // routing matrix side
    input wire logic [5:0] rx_read_channel,
    output logic [31:0] rx_read_data,
    input wire logic tx_write_en,
    input wire logic [5:0] tx_write_channel,
    input wire logic [31:0] tx_write_data
);

    // frame length in bit clocks
    function automatic logic [9:0] flen(input logic [15:0] c, input logic cap16);
        case (c[tsap_pkg::SLOT_LSB +: 3])
            tsap_pkg::SLOT_4X32: flen = 10'h080;
            tsap_pkg::SLOT_8X32: flen = 10'h100;
            tsap_pkg::SLOT_16X32: flen = cap16 ? 10'h200 : 10'h100;
            tsap_pkg::SLOT_4X16: flen = 10'h040;
            tsap_pkg::SLOT_2X16: flen = 10'h020;
            default: flen = 10'h040;
        endcase
    endfunction

    // true for the two 16-clock slot modes
    function automatic logic slot16(input logic [15:0] c);
        slot16 = c[tsap_pkg::SLOT_LSB +: 3] == tsap_pkg::SLOT_4X16 || c[tsap_pkg::SLOT_LSB +: 3] == tsap_pkg::SLOT_2X16;
    endfunction

    // slots in use for a format word
    function automatic logic [4:0] nslot(input logic [15:0] c, input logic cap16);
        logic [9:0] n;
        n = slot16(c) ? flen(c, cap16) >> 4 : flen(c, cap16) >> 5;
        nslot = n[4:0];
    endfunction

    // frame bit to {in word, last bit, slot, word bit index}
    function automatic logic [10:0] place(input logic [15:0] c, input logic [8:0] b, input logic cap16);
        logic [9:0] len;
        logic [9:0] rel;
        logic [8:0] dly;
        logic [5:0] wl;
        logic [4:0] idx;
        logic [3:0] slot;
        len = flen(c, cap16);
        case (c[tsap_pkg::MSB_POS_LSB +: 2])
            2'h0: dly = tsap_pkg::DLY_POS0;
            2'h1: dly = tsap_pkg::DLY_POS1;
            2'h2: dly = tsap_pkg::DLY_POS2;
            default: dly = tsap_pkg::DLY_POS3;
        endcase
        // flexible code counts as 32 bits on ports 2 and 3 only
        if (slot16(c) || c[tsap_pkg::WL_LSB +: 2] == tsap_pkg::WL_16) begin
            wl = 6'h10;
        end else if (c[tsap_pkg::WL_LSB +: 2] == tsap_pkg::WL_32 ||
                     (c[tsap_pkg::WL_LSB +: 2] == tsap_pkg::WL_FLEX && !cap16)) begin
            wl = 6'h20;
        end else begin
            wl = 6'h18;
        end
        // a word may spill past its slot and wrap into the next frame, as i2s does
        rel = {1'b0, b} + len - {1'b0, dly};
        if (rel >= len) begin
            rel = rel - len;
        end
        idx = slot16(c) ? {1'b0, rel[3:0]} : rel[4:0];
        slot = slot16(c) ? rel[7:4] : rel[8:5];
        place = {{1'b0, idx} < wl, {1'b0, idx} == wl - 6'h01, slot, 5'h1f - idx};
    endfunction

    // channel to {valid, port, slot}
    function automatic logic [6:0] chan_map(input logic [5:0] ch);
        logic [5:0] s;
        s = 6'h00;
        if (ch < 6'h10) begin
            chan_map = {3'b100, ch[3:0]};
        end else if (ch < 6'h20) begin
            chan_map = {3'b101, ch[3:0]};
        end else if (ch < 6'h28) begin
            s = ch - 6'h20;
            chan_map = {3'b110, s[3:0]};
        end else if (ch < 6'h30) begin
            s = ch - 6'h28;
            chan_map = {3'b111, s[3:0]};
        end else begin
            chan_map = 7'h00;
        end
    endfunction

    // format word address test
    function automatic logic is_fmt(input logic [15:0] a);
        is_fmt = a[15:5] == tsap_pkg::FMT_BASE_ADDR[15:5] && a[1:0] == 2'h0;
    endfunction

    logic [19:0] pin_meta_q;
    logic [19:0] pin_sync_q;
    logic [15:0] fmt_q [8];
    logic [7:0] fault_q;
    logic [7:0] frame_ok;
    logic [7:0] fault_set;
    logic [7:0] bclk_out;
    logic [7:0] bclk_oe;
    logic [7:0] fclk_out;
    logic [7:0] fclk_oe;
    logic [3:0] sdo;
    logic [31:0] rd_word [4];
    tsap_pkg::tsap_ahb_state_t ahb_q;
    logic [15:0] addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic [31:0] rd_val;
    logic [31:0] rx_read_q;

    // pin synchronisers; only the second stage feeds logic
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_q <= 20'h0_0000;
            pin_sync_q <= 20'h0_0000;
        end else begin
            pin_meta_q <= {serial_in_line_3, serial_in_line_2, serial_in_line_1, serial_in_line_0,
                           output_frame_clock_pin_i, output_bit_clock_pin_i,
                           input_frame_clock_pin_i, input_bit_clock_pin_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    // one engine per port: 0-3 receive, 4-7 transmit
    for (genvar i = 0; i < 8; i++) begin : g_port
        localparam bit IS_TX = (i >= 4);
        localparam int P = i % 4;
        localparam bit CAP16 = (P < 2);
        localparam int DOM = IS_TX ? 8 : 0;
        logic [15:0] cfg_q;
        logic [15:0] cfg_n;
        logic [15:0] shd;
        logic bsel;
        logic fsel;
        logic b_prev_q;
        logic f_prev_q;
        logic act;
        logic samp;
        logic launch;
        logic fstart;
        logic [8:0] cnt_q;
        logic [8:0] b_now;
        logic [9:0] cnt_inc;
        logic [10:0] pl;
        logic [15:0] div_q;
        logic gen_b_q;
        logic gen_f_q;
        logic [8:0] gen_bit_q;
        logic [9:0] gen_inc;
        logic [8:0] gen_nxt;
        logic boe_q;
        logic foe_q;
        logic [23:0] fcnt_q;
        logic ok_q;
        logic fault_q1;
        logic [31:0] mem_q [16];

        assign shd = fmt_q[i];
        // master uses its own generated clocks, slave one of four synced domains
        assign bsel = shd[tsap_pkg::BIT_SRC_LSB +: 3] == tsap_pkg::SRC_MASTER ? gen_b_q :
                      pin_sync_q[DOM + 32'(shd[tsap_pkg::BIT_SRC_LSB +: 2])];
        assign fsel = shd[tsap_pkg::FRAME_SRC_LSB +: 3] == tsap_pkg::SRC_MASTER ? gen_f_q :
                      pin_sync_q[DOM + 4 + 32'(shd[tsap_pkg::FRAME_SRC_LSB +: 2])];
        assign act = cfg_q[tsap_pkg::FRAME_MODE_BIT] ^ cfg_q[tsap_pkg::FRAME_POL_BIT];
        assign samp = bsel != b_prev_q && bsel != cfg_q[tsap_pkg::BIT_POL_BIT];
        assign launch = bsel != b_prev_q && bsel == cfg_q[tsap_pkg::BIT_POL_BIT];
        assign fstart = samp && fsel == act && f_prev_q != act;
        assign cfg_n = fstart ? shd : cfg_q;
        assign b_now = fstart ? 9'h000 : cnt_q;
        assign cnt_inc = {1'b0, b_now} + 10'h001;
        assign pl = IS_TX ? place(cfg_q, cnt_q, CAP16) : place(cfg_n, b_now, CAP16);
        assign gen_inc = {1'b0, gen_bit_q} + 10'h001;
        assign gen_nxt = gen_inc >= flen(cfg_q, CAP16) ? 9'h000 : gen_inc[8:0];
        assign bclk_out[i] = gen_b_q;
        assign fclk_out[i] = gen_f_q;
        assign bclk_oe[i] = boe_q;
        assign fclk_oe[i] = foe_q;
        assign frame_ok[i] = ok_q;
        assign fault_set[i] = fault_q1;

        // bit counter and active format, reloaded only at frame start
        always_ff @(posedge clk) begin
            if (reset) begin
                b_prev_q <= 1'b0;
                f_prev_q <= 1'b0;
                cnt_q <= 9'h000;
                cfg_q <= tsap_pkg::FMT_RESET;
            end else begin
                b_prev_q <= bsel;
                if (samp) begin
                    f_prev_q <= fsel;
                    cfg_q <= cfg_n;
                    cnt_q <= cnt_inc >= flen(cfg_n, CAP16) ? 9'h000 : cnt_inc[8:0];
                end
            end
        end

        // master clock generator; frame and data move on the launch edge
        always_ff @(posedge clk) begin
            if (reset) begin
                div_q <= 16'h0000;
                gen_b_q <= 1'b0;
                gen_f_q <= 1'b0;
                gen_bit_q <= 9'h000;
                boe_q <= 1'b0;
                foe_q <= 1'b0;
            end else begin
                boe_q <= shd[tsap_pkg::BIT_SRC_LSB +: 3] == tsap_pkg::SRC_MASTER;
                foe_q <= shd[tsap_pkg::FRAME_SRC_LSB +: 3] == tsap_pkg::SRC_MASTER;
                if (div_q == 16'(HALF_DIV - 1)) begin
                    div_q <= 16'h0000;
                    gen_b_q <= ~gen_b_q;
                    if (~gen_b_q == cfg_q[tsap_pkg::BIT_POL_BIT]) begin
                        gen_bit_q <= gen_nxt;
                        // half-frame square wave or a one-clock pulse at frame start
                        if (cfg_q[tsap_pkg::FRAME_MODE_BIT] ? gen_nxt == 9'h000 :
                            {1'b0, gen_nxt} < (flen(cfg_q, CAP16) >> 1)) begin
                            gen_f_q <= act;
                        end else begin
                            gen_f_q <= ~act;
                        end
                    end
                end else begin
                    div_q <= div_q + 16'h0001;
                end
            end
        end

        // frame rate watch: too fast or no frame within the longest period
        always_ff @(posedge clk) begin
            if (reset) begin
                fcnt_q <= 24'h00_0000;
                ok_q <= 1'b0;
                fault_q1 <= 1'b0;
            end else begin
                fault_q1 <= 1'b0;
                if (fstart) begin
                    fcnt_q <= 24'h00_0000;
                    ok_q <= 1'b1;
                    fault_q1 <= ok_q && fcnt_q < 24'(tsap_pkg::FRAME_MIN_CYCLES - 1);
                end else if (fcnt_q >= 24'(FRAME_MAX_CYC - 1)) begin
                    ok_q <= 1'b0;
                    fault_q1 <= ok_q;
                end else begin
                    fcnt_q <= fcnt_q + 24'h00_0001;
                end
            end
        end

        if (IS_TX) begin : g_tx
            logic sdo_q;
            logic [6:0] tmap;
            assign sdo[P] = sdo_q;
            assign tmap = chan_map(tx_write_channel);
            // matrix writes; a word rewritten mid-slot may go out torn
            always_ff @(posedge clk) begin
                if (tx_write_en && tmap[6:4] == {1'b1, 2'(P)}) begin
                    mem_q[tmap[3:0]] <= tx_write_data;
                end
            end
            // msb first, zero outside the word
            always_ff @(posedge clk) begin
                if (reset) begin
                    sdo_q <= 1'b0;
                end else if (launch) begin
                    sdo_q <= pl[10] && mem_q[pl[8:5]][pl[4:0]];
                end
            end
        end else begin : g_rx
            logic [31:0] sh_q;
            logic [31:0] rx_word;
            logic [6:0] rmap;
            assign rx_word = (pl[4:0] == 5'h1f ? 32'h0000_0000 : sh_q) | (32'(pin_sync_q[16 + P]) << pl[4:0]);
            assign rmap = chan_map(rx_read_channel);
            // channels beyond the slot count read as zero
            assign rd_word[P] = rmap[6] && rmap[5:4] == 2'(P) && {1'b0, rmap[3:0]} < nslot(cfg_q, CAP16) ?
                                mem_q[rmap[3:0]] : 32'h0000_0000;
            // left-aligned word capture, stored on its last bit
            always_ff @(posedge clk) begin
                if (reset) begin
                    sh_q <= 32'h0000_0000;
                end else if (samp && pl[10]) begin
                    sh_q <= rx_word;
                end
            end
            always_ff @(posedge clk) begin
                if (samp && pl[10] && pl[9]) begin
                    mem_q[pl[8:5]] <= rx_word;
                end
            end
        end
    end

    // pin drivers, each from its own port
    assign input_bit_clock_pin_o = bclk_out[3:0];
    assign input_bit_clock_pin_oe = bclk_oe[3:0];
    assign input_frame_clock_pin_o = fclk_out[3:0];
    assign input_frame_clock_pin_oe = fclk_oe[3:0];
    assign output_bit_clock_pin_o = bclk_out[7:4];
    assign output_bit_clock_pin_oe = bclk_oe[7:4];
    assign output_frame_clock_pin_o = fclk_out[7:4];
    assign output_frame_clock_pin_oe = fclk_oe[7:4];
    assign serial_out_line_0 = sdo[0];
    assign serial_out_line_1 = sdo[1];
    assign serial_out_line_2 = sdo[2];
    assign serial_out_line_3 = sdo[3];

    // matrix read port, one cycle latency
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_read_q <= 32'h0000_0000;
        end else begin
            rx_read_q <= rd_word[0] | rd_word[1] | rd_word[2] | rd_word[3];
        end
    end
    assign rx_read_data = rx_read_q;

    // ahb-lite: writes zero wait, reads one wait state so data comes from a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            ahb_q <= tsap_pkg::AHB_IDLE;
            addr_q <= 16'h0000;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
            case (ahb_q)
                tsap_pkg::AHB_READ: begin
                    hrdata_q <= rd_val;
                    hreadyout_q <= 1'b1;
                    ahb_q <= tsap_pkg::AHB_IDLE;
                end
                default: begin
                    if (hsel && htrans[1] && hready) begin
                        addr_q <= haddr[15:0];
                        hreadyout_q <= hwrite;
                        ahb_q <= hwrite ? tsap_pkg::AHB_WRITE : tsap_pkg::AHB_READ;
                    end else begin
                        ahb_q <= tsap_pkg::AHB_IDLE;
                    end
                end
            endcase
        end
    end
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

    // read decode; unmapped reads zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (addr_q == tsap_pkg::STATUS_ADDR) begin
            rd_val = {16'h0000, fault_q, frame_ok};
        end else if (is_fmt(addr_q)) begin
            rd_val = {16'h0000, fmt_q[addr_q[4:2]]};
        end
    end

    // format words, one per port
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int k = 0; k < 8; k++) begin
                fmt_q[k] <= tsap_pkg::FMT_RESET;
            end
        end else if (ahb_q == tsap_pkg::AHB_WRITE && is_fmt(addr_q)) begin
            fmt_q[addr_q[4:2]] <= hwdata[15:0];
        end
    end

    // sticky rate faults, write one to clear; a new fault wins over the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_q <= tsap_pkg::FAULT_RESET;
        end else if (ahb_q == tsap_pkg::AHB_WRITE && addr_q == tsap_pkg::STATUS_ADDR) begin
            fault_q <= (fault_q & ~hwdata[15:8]) | fault_set;
        end else begin
            fault_q <= fault_q | fault_set;
        end
    end

endmodule

// [tb/tsap_properties.sv]
// concurrent checks on the top level of the serial audio ports
`timescale 1ns/1ps
module tsap_props #(
    parameter int FRAME_MAX_CYC = 2000,
    parameter int HALF_DIV = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // matrix and port 1 pins
    input wire logic [5:0] rx_read_channel,
    input wire logic [31:0] rx_read_data,
    input wire logic serial_out_line_1,
    input wire logic [3:0] output_bit_clock_pin_o,
    input wire logic [3:0] output_bit_clock_pin_oe,
    input wire logic [3:0] output_frame_clock_pin_o
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    logic [15:0] bit_cnt_q;
    logic [15:0] frm_cnt_q;
    logic [1:0] seen_q;
    wire take = hsel && htrans[1] && hready;
    // cycles since each master clock last moved; the first move after enable only arms the check
    always_ff @(posedge clk) begin
        if (reset || !output_bit_clock_pin_oe[1]) begin
            bit_cnt_q <= 16'h0000;
            frm_cnt_q <= 16'h0000;
            seen_q <= 2'h0;
        end else begin
            bit_cnt_q <= $changed(output_bit_clock_pin_o[1]) ? 16'h0000 : bit_cnt_q + 16'h0001;
            frm_cnt_q <= $changed(output_frame_clock_pin_o[1]) ? 16'h0000 : frm_cnt_q + 16'h0001;
            seen_q <= seen_q | {$changed(output_frame_clock_pin_o[1]), $changed(output_bit_clock_pin_o[1])};
        end
    end
    rd_one_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    wr_zero_wait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    rd_data_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("error response given");
    rx_range_zero_a: assert property (rx_read_channel > 6'h2f |=> rx_read_data == 32'h0000_0000)
        else $error("channel out of range not zero");
    reset_quiet_a: assert property ($fell(reset) |-> output_bit_clock_pin_oe == 4'h0)
        else $error("clock pin driven after reset");
    bclk_half_a: assert property (seen_q[0] && $changed(output_bit_clock_pin_o[1]) |-> bit_cnt_q == HALF_DIV - 1)
        else $error("master bit clock half period wrong");
    frame_half_a: assert property (seen_q[1] && $changed(output_frame_clock_pin_o[1]) |-> frm_cnt_q == 64 * HALF_DIV - 1)
        else $error("master frame half length wrong");
    launch_edge_a: assert property (output_bit_clock_pin_oe[1] && $changed(serial_out_line_1) |-> !output_bit_clock_pin_o[1])
        else $error("data launched on sampling phase");
    // main scenarios
    rd_seen_c: cover property (take && !hwrite);
    frame_seen_c: cover property (seen_q[1] && $changed(output_frame_clock_pin_o[1]));
    range_seen_c: cover property (rx_read_channel > 6'h2f);
endmodule
bind tsap_top tsap_props #(.FRAME_MAX_CYC(FRAME_MAX_CYC), .HALF_DIV(HALF_DIV)) i_tsap_props (
    .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_read_channel(rx_read_channel), .rx_read_data(rx_read_data),
    .serial_out_line_1(serial_out_line_1), .output_bit_clock_pin_o(output_bit_clock_pin_o),
    .output_bit_clock_pin_oe(output_bit_clock_pin_oe), .output_frame_clock_pin_o(output_frame_clock_pin_o));

// [tb/tsap_codec.sv]
// codec model: clocks and feeds input domain 0, listens to output port 1
`timescale 1ns/1ps
module tsap_codec (
    // toward input domain 0
    output logic bc,
    output logic lr,
    output logic sd,
    // from output port 1
    input wire logic obc,
    input wire logic olr,
    input wire logic osd
);
    // idle: clock still, frame pin inactive
    initial begin
        bc = 1'b0;
        lr = 1'b1;
        sd = 1'b0;
    end
    // one 2x16 frame, msb first; the gap after it keeps the frame rate legal
    task automatic play(input logic [31:0] frm);
        for (int i = 0; i < 32; i++) begin
            lr <= i > 15;
            sd <= frm[31 - i];
            #40 bc <= 1'b1;
            #40 bc <= 1'b0;
        end
        sd <= ~frm[0];
        #2700;
    endtask
    // capture both 32-bit slots of the next frame on the sampling edge
    task automatic hear(output logic [31:0] a, output logic [31:0] b);
        logic [63:0] sh;
        @(negedge olr);
        for (int i = 0; i < 64; i++) begin
            @(posedge obc);
            sh = {sh[62:0], osd};
        end
        a = sh[63:32];
        b = sh[31:0];
    endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the tdm serial audio ports
`timescale 1ns/1ps
module tb;
    logic clk, reset, hsel, hwrite, hreadyout, so1, cbc, clr, csd, twe, got_v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] ibc_o, ibc_oe, ilr_o, ilr_oe, obc_o, obc_oe, olr_o, olr_oe;
    logic [5:0] rch, tch;
    logic [31:0] haddr, hwdata, hrdata, rdat, twd, got_d, e, w16, w17, win, a, b;
    logic [31:0] exp_q[$];
    int fails, comparisons;
    wire [3:0] ibc = (ibc_oe & ibc_o) | (~ibc_oe & {3'h0, cbc});
    wire [3:0] ilr = (ilr_oe & ilr_o) | (~ilr_oe & {3'h0, clr});
    tsap_top #(.FRAME_MAX_CYC(2000), .HALF_DIV(10)) i_tsap_top (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .serial_in_line_0(csd), .serial_in_line_1(csd), .serial_in_line_2(csd), .serial_in_line_3(csd),
        .serial_out_line_0(), .serial_out_line_1(so1), .serial_out_line_2(), .serial_out_line_3(),
        .input_bit_clock_pin_i(ibc), .input_bit_clock_pin_o(ibc_o), .input_bit_clock_pin_oe(ibc_oe),
        .input_frame_clock_pin_i(ilr), .input_frame_clock_pin_o(ilr_o), .input_frame_clock_pin_oe(ilr_oe),
        .output_bit_clock_pin_i(obc_o & obc_oe), .output_bit_clock_pin_o(obc_o), .output_bit_clock_pin_oe(obc_oe),
        .output_frame_clock_pin_i(olr_o & olr_oe), .output_frame_clock_pin_o(olr_o),
        .output_frame_clock_pin_oe(olr_oe), .rx_read_channel(rch), .rx_read_data(rdat),
        .tx_write_en(twe), .tx_write_channel(tch), .tx_write_data(twd));
    tsap_codec i_tsap_codec (.bc(cbc), .lr(clr), .sd(csd), .obc(obc_o[1]), .olr(olr_o[1]), .osd(so1));
    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // note an expectation and present the matching result for one cycle
    task automatic note(input logic [31:0] ex, input logic [31:0] g);
        @(posedge clk);
        exp_q.push_back(ex);
        got_d <= g;
        got_v <= 1'b1;
        @(posedge clk);
        got_v <= 1'b0;
    endtask
    // single ahb-lite word transfer; a read notes its expected data
    task automatic ahb(input logic wr, input logic [15:0] ad, input logic [31:0] d, input logic [31:0] ex);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {16'h0000, ad};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        if (!wr) note(ex, hrdata);
    endtask
    // read one matrix channel, data one cycle after the channel
    task automatic rx(input logic [5:0] c, input logic [31:0] ex);
        rch <= c;
        @(posedge clk);
        @(posedge clk);
        note(ex, rdat);
    endtask
    // compare each result with the oldest note
    always @(posedge clk) begin
        if (got_v === 1'b1) begin
            e = exp_q.pop_front();
            comparisons++;
            if (got_d !== e) begin
                fails++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got_d, e);
            end
        end
    end
    task automatic print_verdict;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog, well past the expected run of about 21 us
    initial begin
        #100_000;
        fails++;
        print_verdict;
    end
    // main sequence
    initial begin
        {reset, hsel, htrans, hwrite, hsize, haddr, hwdata} = {1'h1, 1'h1, 2'h0, 1'h0, 3'h2, 64'h0};
        {rch, tch, twe, twd, got_v, got_d} = '0;
        void'($urandom(32'h9079));
        w16 = $urandom;
        w17 = $urandom;
        win = $urandom;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        ahb(1'b0, 16'hf214, 32'h0000_0000, 32'h0000_0000);
        ahb(1'b0, 16'hf230, 32'h0000_0000, 32'h0000_0000);
        ahb(1'b0, 16'hf220, 32'h0000_0000, 32'h0000_0000);
        twe <= 1'b1;
        tch <= 6'h10;
        twd <= w16;
        @(posedge clk);
        tch <= 6'h11;
        twd <= w17;
        @(posedge clk);
        twe <= 1'b0;
        ahb(1'b1, 16'hf214, 32'ha5a5_9048, 32'h0000_0000);
        ahb(1'b0, 16'hf214, 32'h0000_0000, 32'h0000_9048);
        ahb(1'b1, 16'hf200, 32'h0000_002d, 32'h0000_0000);
        i_tsap_codec.play(win);
        i_tsap_codec.play(~win);
        @(posedge clk);
        rx(6'h00, {~win[31:16], 16'h0000});
        rx(6'h01, {~win[15:0], 16'h0000});
        rx(6'h02, 32'h0000_0000);
        rx(6'h32, 32'h0000_0000);
        i_tsap_codec.hear(a, b);
        note(w16, a);
        note(w17, b);
        print_verdict;
    end
endmodule
